// file: logic/scr_spi_regs.v
// Contract
// - Bits 7:5 address divider and source
// - Bit 4 enables addressed source
// - Bit 3 sink mode, sources 1-3 only
// - Bit 2 zero gates source by PWM
// - Bit 1 is irq enable when programming
// - Bit 1 is slope disable otherwise
// - Status 15:12 meaning from previous command
// - Previous zero: temperatures and ignition state
// - Previous one: battery visible, shown address
// - Bit 11 watchdog on, bit 10 undervoltage
// - Bits 9:8 irq source, cleared after readout
// - Bits 7:0 comparator results 8..1
// - Sixteen bits, MSB first, both directions
// - Changes visible in next status word
// - Per-source bits loaded only when programming
`timescale 1ns/100ps
`default_nettype none
`include "scr_defines.vh"
module scr_spi_regs #(
    parameter NSRC = 8
) (
    input wire i_clock,
    input wire i_sys_rst,
    input wire i_sck,
    input wire i_chip_select_n,
    input wire i_mosi,
    output wire o_miso,
    output wire o_miso_oe,
    input wire i_reg_overtemp_warn,
    input wire i_lin_driver_overtemp,
    input wire i_src_overtemp,
    input wire i_ignition_line_state,
    input wire i_batt_divider_visible,
    input wire i_vs_undervoltage,
    input wire i_divider_out_pin,
    input wire [1:0] i_irq_source,
    input wire i_irq_event,
    input wire [NSRC-1:0] i_switch_cmp_result,
    input wire [2:0] i_gate_pwm_pin,
    output reg [15:0] o_cfg_upper,
    output reg [2:0] o_sw_addr,
    output reg [NSRC-1:0] o_src_on,
    output reg [NSRC-1:0] o_sink_select,
    output reg [NSRC-1:0] o_switch_irq_enable,
    output reg o_slope_ctrl_disable,
    output reg o_wdog_disable,
    output reg o_wdog_state
);
    reg [2:0] sck_s_r, cs_s_r;
    reg [1:0] mosi_s_r;
    reg [1:0] pwm_s1_r [0:2];
    reg [2:0] pwm_q_r;
    reg [15:0] rx_r, tx_r;
    reg [4:0] cnt_r;
    reg miso_r;
    reg [NSRC-1:0] en_r, mode_r;
    reg prev_div_en_r;
    reg [1:0] irq_src_r;
    reg irq_valid_r;
    integer i, j, k;
    wire sck_rise = sck_s_r[1] & ~sck_s_r[2];
    wire sck_fall = ~sck_s_r[1] & sck_s_r[2];
    wire cs_act = ~cs_s_r[1];
    wire cs_start = ~cs_s_r[1] & cs_s_r[2];
    wire cs_end = cs_s_r[1] & ~cs_s_r[2];
    wire [15:0] status;

    // Map source index to its PWM port
    function [1:0] pwm_of;
        input [2:0] idx;
        begin
            case (idx)
                3'h0, 3'h6, 3'h7: pwm_of = 2'h0;
                3'h1, 3'h4, 3'h5: pwm_of = 2'h1;
                default: pwm_of = 2'h2;
            endcase
        end
    endfunction

    always @(posedge i_clock) begin
        sck_s_r <= {sck_s_r[1:0], i_sck};
        cs_s_r <= {cs_s_r[1:0], i_chip_select_n};
        mosi_s_r <= {mosi_s_r[0], i_mosi};
        for (j = 0; j < 3; j = j + 1) begin
            pwm_s1_r[j] <= {pwm_s1_r[j][0], i_gate_pwm_pin[j]};
            pwm_q_r[j] <= pwm_s1_r[j][1];
        end
    end

    assign status[15] = prev_div_en_r ? i_batt_divider_visible
                                      : i_reg_overtemp_warn;
    assign status[14:12] = prev_div_en_r ? o_sw_addr
        : {i_lin_driver_overtemp, i_src_overtemp, i_ignition_line_state};
    assign status[`SCR_ST_WDOG] = o_wdog_state;
    assign status[`SCR_ST_UNDERV] = i_vs_undervoltage;
    assign status[`SCR_ST_IRQ_HI:`SCR_ST_IRQ_LO] = irq_src_r;
    assign status[7:0] = i_switch_cmp_result[7:0];

    assign o_miso = miso_r;
    assign o_miso_oe = cs_act;

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            rx_r <= `SCR_CFG_RESET;
            tx_r <= 16'h0000;
            cnt_r <= 5'h00;
            miso_r <= 1'b0;
            o_cfg_upper <= `SCR_CFG_RESET;
            o_sw_addr <= 3'h0;
            en_r <= {NSRC{1'b0}};
            mode_r <= {NSRC{1'b0}};
            o_sink_select <= {NSRC{1'b0}};
            o_switch_irq_enable <= {NSRC{1'b0}};
            o_slope_ctrl_disable <= 1'b0;
            o_wdog_disable <= 1'b0;
            o_wdog_state <= 1'b0;
            prev_div_en_r <= 1'b0;
            irq_src_r <= 2'h0;
            irq_valid_r <= 1'b0;
        end else begin
            o_wdog_state <= ~o_wdog_disable & ~i_divider_out_pin;
            if (cs_start) begin
                tx_r <= {status[14:0], 1'b0};
                miso_r <= status[15];
                cnt_r <= 5'h00;
            end else if (cs_act && sck_rise) begin
                rx_r <= {rx_r[14:0], mosi_s_r[1]};
                if (cnt_r != 5'h1f)
                    cnt_r <= cnt_r + 5'h01;
            end else if (cs_act && sck_fall && cnt_r != 5'h00) begin
                miso_r <= tx_r[15];
                tx_r <= {tx_r[14:0], 1'b0};
            end
            if (i_irq_event) begin
                irq_src_r <= i_irq_source;
                irq_valid_r <= 1'b1;
            end else if (cs_end && cnt_r == 5'h10 && irq_valid_r) begin
                irq_src_r <= 2'h0;
                irq_valid_r <= 1'b0;
            end
            if (cs_end && cnt_r == 5'h10) begin
                o_cfg_upper <= {rx_r[15:8], 8'h00};
                prev_div_en_r <= rx_r[`SCR_CFG_DIV_OUT_EN];
                o_sw_addr <= rx_r[`SCR_CFG_ADDR_HI:`SCR_CFG_ADDR_LO];
                o_wdog_disable <= rx_r[`SCR_CFG_WDOG_DIS];
                if (rx_r[`SCR_CFG_PROG_EN]) begin
                    for (i = 0; i < NSRC; i = i + 1) begin
                        if (i == rx_r[7:5]) begin
                            en_r[i] <= rx_r[`SCR_CFG_SRC_EN];
                            o_sink_select[i] <= rx_r[`SCR_CFG_SINK] &
                                (rx_r[7:5] <= `SCR_SINK_MAX_IDX);
                            mode_r[i] <= rx_r[`SCR_CFG_CTRL_MODE];
                            o_switch_irq_enable[i] <=
                                rx_r[`SCR_CFG_IRQ_SLOPE];
                        end
                    end
                end else begin
                    o_slope_ctrl_disable <= rx_r[`SCR_CFG_IRQ_SLOPE];
                end
            end
        end
    end

    always @(posedge i_clock) begin
        if (i_sys_rst) begin
            o_src_on <= {NSRC{1'b0}};
        end else begin
            for (k = 0; k < NSRC; k = k + 1) begin
                o_src_on[k] <= en_r[k] &
                    (mode_r[k] | pwm_q_r[pwm_of(k[2:0])]);
            end
        end
    end
endmodule // scr_spi_regs
`default_nettype wire

// file: logic/scr_defines.vh
`ifndef SCR_DEFINES_VH
`define SCR_DEFINES_VH
`define SCR_WORD_BITS 16
`define SCR_CFG_ADDR_HI 7
`define SCR_CFG_ADDR_LO 5
`define SCR_CFG_SRC_EN 4
`define SCR_CFG_SINK 3
`define SCR_CFG_CTRL_MODE 2
`define SCR_CFG_IRQ_SLOPE 1
`define SCR_CFG_WDOG_DIS 0
`define SCR_CFG_PROG_EN 8
`define SCR_CFG_DIV_OUT_EN 10
`define SCR_ST_B15 15
`define SCR_ST_B14 14
`define SCR_ST_B13 13
`define SCR_ST_B12 12
`define SCR_ST_WDOG 11
`define SCR_ST_UNDERV 10
`define SCR_ST_IRQ_HI 9
`define SCR_ST_IRQ_LO 8
`define SCR_SINK_MAX_IDX 3'h2
`define SCR_CFG_RESET 16'h0000
`endif

// file: dv/scr_spi_regs_sva.sv
`timescale 1ns/100ps
`default_nettype none
module scr_spi_regs_sva #(
    parameter NSRC = 8
) (
    input wire logic i_clock,
    input wire logic i_sys_rst,
    input wire logic i_chip_select_n,
    input wire logic i_divider_out_pin,
    input wire logic o_miso_oe,
    input wire logic [15:0] o_cfg_upper,
    input wire logic [2:0] o_sw_addr,
    input wire logic [NSRC-1:0] o_sink_select,
    input wire logic [NSRC-1:0] o_switch_irq_enable,
    input wire logic o_slope_ctrl_disable,
    input wire logic o_wdog_disable,
    input wire logic o_wdog_state
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_sys_rst);
    a_sink_low_only: assert property (o_sink_select[7:3] == 5'h00)
        else $error("sink on high-side source");
    a_upper_low_zero: assert property (o_cfg_upper[7:0] == 8'h00)
        else $error("upper word low byte set");
    a_wdog_follow: assert property (!$past(i_sys_rst) &&
        $stable(o_wdog_disable) && $stable(i_divider_out_pin) |->
        o_wdog_state == (!o_wdog_disable && !i_divider_out_pin))
        else $error("watchdog state wrong");
    a_oe_on_select: assert property ($fell(i_chip_select_n) |->
        ##[1:4] o_miso_oe) else $error("output not enabled");
    a_oe_idle_off: assert property (i_chip_select_n [*5] |->
        !o_miso_oe) else $error("output driven while idle");
    a_addr_after_frame: assert property ($changed(o_sw_addr) |->
        $past(i_chip_select_n, 2)) else $error("address changed in frame");
    a_irqen_after_frame: assert property ($changed(o_switch_irq_enable)
        |-> $past(i_chip_select_n, 2)) else $error("irq enable early");
    a_slope_alone: assert property ($changed(o_slope_ctrl_disable) |->
        $stable(o_switch_irq_enable) && $past(i_chip_select_n, 2))
        else $error("slope changed with source bits");
    c_slope: cover property ($rose(o_slope_ctrl_disable));
    c_irqen: cover property ($changed(o_switch_irq_enable));
    c_wdog: cover property ($fell(o_wdog_state));
endmodule // scr_spi_regs_sva
bind scr_spi_regs scr_spi_regs_sva #(.NSRC(NSRC)) u_sva (.i_clock,
    .i_sys_rst, .i_chip_select_n, .i_divider_out_pin, .o_miso_oe,
    .o_cfg_upper, .o_sw_addr, .o_sink_select, .o_switch_irq_enable,
    .o_slope_ctrl_disable, .o_wdog_disable, .o_wdog_state);
`default_nettype wire

// file: dv/scr_spi_host.sv
`timescale 1ns/100ps
`default_nettype none
module scr_spi_host (
    input wire logic i_clock,
    input wire logic i_miso,
    output logic o_sck = 0,
    output logic o_cs_n = 1,
    output logic o_mosi = 0
);
    task automatic xfer(input [15:0] tx, input int n, output [15:0] rx);
        @(posedge i_clock) o_cs_n <= 0;
        repeat (6) @(posedge i_clock);
        for (int i = 15; i > 15 - n; i--) begin
            o_mosi <= tx[i];
            repeat (8) @(posedge i_clock);
            o_sck <= 1;
            rx = {rx[14:0], i_miso};
            repeat (8) @(posedge i_clock);
            o_sck <= 0;
        end
        repeat (8) @(posedge i_clock);
        o_cs_n <= 1;
        o_mosi <= ~o_mosi;
        repeat (12) @(posedge i_clock);
    endtask
endmodule // scr_spi_host
`default_nettype wire

// file: dv/test_scr_spi_regs.sv
`timescale 1ns/100ps
`default_nettype none
module test_scr_spi_regs;
    localparam logic [15:0] PM = 16'h05a4;
    logic clk = 0, rst = 1, ev = 0, pv = 0, wdog_disable = 0, sl = 0;
    logic [15:0] st = 0, rx, r = 16'h0056, q[$];
    logic [7:0] en = 0, sk = 0, md = 0, ie = 0;
    logic [2:0] la = 0;
    logic [1:0] isr = 0, irq = 0;
    int fail_count = 0, n_checks = 0;
    wire sck, cs_n, mosi, miso, oe, slp, wd, ws;
    wire [15:0] up;
    wire [7:0] on, sko, ieo;
    wire [2:0] adr;
    event got;
    scr_spi_regs dut (.i_clock(clk), .i_sys_rst(rst), .i_sck(sck),
        .i_chip_select_n(cs_n), .i_mosi(mosi), .o_miso(miso),
        .o_miso_oe(oe), .i_reg_overtemp_warn(st[8]),
        .i_lin_driver_overtemp(st[9]), .i_src_overtemp(st[10]),
        .i_ignition_line_state(st[11]), .i_batt_divider_visible(st[12]),
        .i_vs_undervoltage(st[13]), .i_divider_out_pin(st[14]),
        .i_irq_source(isr), .i_irq_event(ev),
        .i_switch_cmp_result(st[7:0]), .i_gate_pwm_pin(st[14:12]),
        .o_cfg_upper(up), .o_sw_addr(adr), .o_src_on(on),
        .o_sink_select(sko), .o_switch_irq_enable(ieo),
        .o_slope_ctrl_disable(slp), .o_wdog_disable(wd), .o_wdog_state(ws));
    scr_spi_host host (.i_clock(clk), .i_miso(oe ? miso : ~miso),
        .o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi));
    initial forever #5 clk = ~clk;
    function automatic logic [15:0] lf(input logic [15:0] v);
        return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
    endfunction
    task automatic chk(input logic [15:0] g, input logic [15:0] e);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic results;
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic frame(input logic [15:0] tx);
        logic [2:0] a;
        a = tx[7:5];
        r = lf(r);
        @(posedge clk) st <= r;
        repeat (3) @(posedge clk);
        q.push_back({pv ? {r[12], la} : {r[8], r[9], r[10], r[11]},
            !wdog_disable && !r[14], r[13], irq, r[7:0]});
        host.xfer(tx, 16, rx);
        -> got;
        irq = 0;
        pv = tx[10];
        la = a;
        wdog_disable = tx[0];
        if (tx[8]) begin
            en[a] = tx[4];
            sk[a] = tx[3] && a < 3;
            md[a] = tx[2];
            ie[a] = tx[1];
        end else
            sl = tx[1];
        chk({up[15:8], adr, on[a], sko[a], ieo[a], slp, wd}, {tx[15:8], a,
            en[a] && (md[a] || r[12 + PM[2*a +: 2]]), sk[a], ie[a], sl,
            tx[0]});
    endtask
    initial forever begin
        @(got);
        chk(rx, q.pop_front());
    end
    initial begin
        repeat (8) @(posedge clk);
        rst <= 0;
        for (int k = 0; k < 16; k++) begin
            if (k % 4 == 0) begin
                @(posedge clk) isr <= k[3:2];
                ev <= 1;
                @(posedge clk) ev <= 0;
                irq = k[3:2];
            end
            if (k == 8) host.xfer(~r, 15, rx);
            frame({r[15:11], k[1], r[9], k[0], r[7:0]});
        end
        repeat (20) @(posedge clk);
        results;
    end
    initial begin
        #300us;
        fail_count++;
        results;
    end
endmodule // test_scr_spi_regs
`default_nettype wire
